// *** core/emi_irq_events.sv ***
// interrupt event logic of the mac: completion, threshold, statistics and fault sources
// assumes the dma engines give one-cycle store and fault pulses synchronous to mclk
`timescale 1ns/1ps
module emi_irq_events #(
	parameter int NCH = emi_pkg::NUM_CHAN,
	parameter int NCNT = emi_pkg::NUM_COUNTERS,
	parameter int CW = emi_pkg::CNT_W
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [emi_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [emi_pkg::DAT_W-1:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [emi_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire emi_pkg::emi_store_t tx_store,
	input wire emi_pkg::emi_store_t rx_store,
	input wire logic [emi_pkg::NUM_TX_FAULTS-1:0] tx_fault_flags,
	input wire logic [emi_pkg::CHAN_W-1:0] tx_fault_chan,
	input wire logic [emi_pkg::NUM_RX_FAULTS-1:0] rx_fault_flags,
	input wire logic [emi_pkg::CHAN_W-1:0] rx_fault_chan,
	input wire logic [NCNT-1:0] stat_counter_msb,
	input wire logic [NCH*CW-1:0] rx_free_buffer_count,
	input wire logic [NCH*CW-1:0] rx_flow_threshold,
	output logic [NCH-1:0] tx_done_irq,
	output logic [NCH-1:0] rx_done_irq,
	output logic [NCH-1:0] rx_low_buffers_irq,
	output logic counter_overflow_irq,
	output logic descriptor_fault_irq
);
	typedef struct packed {
		logic [NCH-1:0] tx_en;
		logic [2*NCH-1:0] rx_en;
		logic [1:0] misc_en;
		logic fault_raw;
		logic [15:0] mac_status;
		logic [NCH-1:0] thr_raw;
		logic stat_raw;
		logic [NCH-1:0] out_tx;
		logic [NCH-1:0] out_rx;
		logic [NCH-1:0] out_thr;
		logic out_stat;
		logic out_fault;
	} emi_ev_state_t;

	localparam int DAT_W_L = emi_pkg::DAT_W;

	emi_ev_state_t st;
	emi_ev_state_t next_st;

	emi_pkg::emi_bus_req_t req;
	emi_pkg::emi_store_t tx_host_ack;
	emi_pkg::emi_store_t rx_host_ack;
	logic [emi_pkg::DAT_W-1:0] rd_data;
	logic [emi_pkg::PTR_W-1:0] tx_rd_ptr;
	logic [emi_pkg::PTR_W-1:0] rx_rd_ptr;
	logic [NCH-1:0] tx_pend;
	logic [NCH-1:0] rx_pend;
	logic [NCH-1:0] thr_now;
	logic [DAT_W_L-1:0] wmask;

	////////////////////////////////////////////////////////////////////////////////
	// bus front end and completion pointer stores

	emi_wb_slave u_bus (
		.mclk(mclk),
		.resetn(resetn),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i),
		.rd_data(rd_data),
		.req(req),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o)
	);

	emi_cpl_ptr #(.NCH(NCH)) u_tx_cpl (
		.mclk(mclk),
		.resetn(resetn),
		.dev_store(tx_store),
		.host_ack(tx_host_ack),
		.rd_chan(req.addr[4:2]),
		.rd_ptr(tx_rd_ptr),
		.pend(tx_pend)
	);

	emi_cpl_ptr #(.NCH(NCH)) u_rx_cpl (
		.mclk(mclk),
		.resetn(resetn),
		.dev_store(rx_store),
		.host_ack(rx_host_ack),
		.rd_chan(req.addr[4:2]),
		.rd_ptr(rx_rd_ptr),
		.pend(rx_pend)
	);

	////////////////////////////////////////////////////////////////////////////////
	// free-buffer comparison, the same one flow control uses

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_thr
			assign thr_now[gi] =
				rx_free_buffer_count[gi*CW +: CW] <= rx_flow_threshold[gi*CW +: CW];
		end
	endgenerate

	// byte lanes not selected write as zero, which set/clear treat as no change
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{req.sel[gi]}};
		end
	endgenerate

	// host acknowledges need a full word so a partial compare never clears a pending
	always_comb begin
		tx_host_ack.valid = req.valid && req.we && req.sel == 4'hf &&
			(req.addr & emi_pkg::CP_REGION_MASK) == emi_pkg::TX_CP_BASE;
		tx_host_ack.chan = req.addr[4:2];
		tx_host_ack.addr = req.data;
		rx_host_ack.valid = req.valid && req.we && req.sel == 4'hf &&
			(req.addr & emi_pkg::CP_REGION_MASK) == emi_pkg::RX_CP_BASE;
		rx_host_ack.chan = req.addr[4:2];
		rx_host_ack.addr = req.data;
	end

	////////////////////////////////////////////////////////////////////////////////
	// register read mux

	always_comb begin
		rd_data = 32'h0000_0000;
		if ((req.addr & emi_pkg::CP_REGION_MASK) == emi_pkg::TX_CP_BASE) begin
			rd_data = tx_rd_ptr;
		end else if ((req.addr & emi_pkg::CP_REGION_MASK) == emi_pkg::RX_CP_BASE) begin
			rd_data = rx_rd_ptr;
		end else begin
			case (req.addr)
				emi_pkg::TX_RAW_OFS: rd_data = 32'(tx_pend);
				emi_pkg::TX_MASKED_OFS: rd_data = 32'(tx_pend & st.tx_en);
				emi_pkg::TX_EN_SET_OFS,
				emi_pkg::TX_EN_CLR_OFS: rd_data = 32'(st.tx_en);
				emi_pkg::RX_RAW_OFS: rd_data = 32'({st.thr_raw, rx_pend});
				emi_pkg::RX_MASKED_OFS: rd_data = 32'({st.thr_raw, rx_pend} & st.rx_en);
				emi_pkg::RX_EN_SET_OFS,
				emi_pkg::RX_EN_CLR_OFS: rd_data = 32'(st.rx_en);
				emi_pkg::MISC_RAW_OFS: rd_data = 32'({st.fault_raw, st.stat_raw});
				emi_pkg::MISC_MASKED_OFS:
					rd_data = 32'({st.fault_raw, st.stat_raw} & st.misc_en);
				emi_pkg::MISC_EN_SET_OFS,
				emi_pkg::MISC_EN_CLR_OFS: rd_data = 32'(st.misc_en);
				emi_pkg::MAC_STATUS_OFS: rd_data = 32'(st.mac_status);
				default: rd_data = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// enables, level sources, fault capture and output registers

	always_comb begin
		logic [DAT_W_L-1:0] wd;
		logic [3:0] tx_code;
		logic [3:0] rx_code;
		wd = req.data & wmask;
		tx_code = 4'h0;
		rx_code = 4'h0;
		next_st = st;

		if (req.valid && req.we) begin
			case (req.addr)
				emi_pkg::TX_EN_SET_OFS: next_st.tx_en = st.tx_en | wd[NCH-1:0];
				emi_pkg::TX_EN_CLR_OFS: next_st.tx_en = st.tx_en & ~wd[NCH-1:0];
				emi_pkg::RX_EN_SET_OFS: next_st.rx_en = st.rx_en | wd[2*NCH-1:0];
				emi_pkg::RX_EN_CLR_OFS: next_st.rx_en = st.rx_en & ~wd[2*NCH-1:0];
				emi_pkg::MISC_EN_SET_OFS: next_st.misc_en = st.misc_en | wd[1:0];
				emi_pkg::MISC_EN_CLR_OFS: next_st.misc_en = st.misc_en & ~wd[1:0];
				default: next_st.misc_en = st.misc_en;
			endcase
		end

		// levels follow their causes; host removes them by fixing the cause
		next_st.thr_raw = thr_now;
		next_st.stat_raw = |stat_counter_msb;

		// lowest-numbered condition wins the code when several arrive together
		for (int i = emi_pkg::NUM_TX_FAULTS - 1; i >= 0; i--) begin
			if (tx_fault_flags[i]) begin
				tx_code = 4'(i + 1);
			end
		end
		for (int i = emi_pkg::NUM_RX_FAULTS - 1; i >= 0; i--) begin
			if (rx_fault_flags[i]) begin
				rx_code = 4'(i + 1);
			end
		end

		// only the first fault of each direction is kept; nothing but reset clears it
		if (tx_code != 4'h0) begin
			next_st.fault_raw = 1'b1;
			if (st.mac_status[emi_pkg::ST_TX_CODE_LSB +: 4] == 4'h0) begin
				next_st.mac_status[emi_pkg::ST_TX_CODE_LSB +: 4] = tx_code;
				next_st.mac_status[emi_pkg::ST_TX_CHAN_LSB +: 3] = tx_fault_chan;
			end
		end
		if (rx_code != 4'h0) begin
			next_st.fault_raw = 1'b1;
			if (st.mac_status[emi_pkg::ST_RX_CODE_LSB +: 4] == 4'h0) begin
				next_st.mac_status[emi_pkg::ST_RX_CODE_LSB +: 4] = rx_code;
				next_st.mac_status[emi_pkg::ST_RX_CHAN_LSB +: 3] = rx_fault_chan;
			end
		end

		// outputs lag the status registers by one cycle to stay flop-driven
		next_st.out_tx = tx_pend & next_st.tx_en;
		next_st.out_rx = rx_pend & next_st.rx_en[NCH-1:0];
		next_st.out_thr = st.thr_raw & next_st.rx_en[emi_pkg::RX_THR_LSB +: NCH];
		next_st.out_stat = st.stat_raw & next_st.misc_en[emi_pkg::MISC_STAT_BIT];
		next_st.out_fault = st.fault_raw & next_st.misc_en[emi_pkg::MISC_FAULT_BIT];
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
			st.tx_en <= emi_pkg::TX_EN_RST;
			st.rx_en <= emi_pkg::RX_EN_RST;
			st.misc_en <= emi_pkg::MISC_EN_RST;
			st.mac_status <= emi_pkg::MAC_STATUS_RST;
		end else begin
			st <= next_st;
		end
	end

	assign tx_done_irq = st.out_tx;
	assign rx_done_irq = st.out_rx;
	assign rx_low_buffers_irq = st.out_thr;
	assign counter_overflow_irq = st.out_stat;
	assign descriptor_fault_irq = st.out_fault;
endmodule

// *** core/emi_pkg.sv ***
// shared constants and carriers for the mac interrupt event block
// assumes a 32-bit classic wishbone register port with byte addresses
package emi_pkg;
	localparam int NUM_CHAN = 8;
	localparam int CHAN_W = 3;
	localparam int PTR_W = 32;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int NUM_COUNTERS = 36;
	localparam int CNT_W = 16;
	localparam int NUM_TX_FAULTS = 6;
	localparam int NUM_RX_FAULTS = 2;

	// a statistics counter is in the overflow range once it reaches this value
	localparam logic [31:0] STAT_LIMIT = 32'h8000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [ADR_W-1:0] TX_RAW_OFS = 8'h00;
	localparam logic [ADR_W-1:0] TX_MASKED_OFS = 8'h04;
	localparam logic [ADR_W-1:0] TX_EN_SET_OFS = 8'h08;
	localparam logic [ADR_W-1:0] TX_EN_CLR_OFS = 8'h0c;
	localparam logic [ADR_W-1:0] RX_RAW_OFS = 8'h10;
	localparam logic [ADR_W-1:0] RX_MASKED_OFS = 8'h14;
	localparam logic [ADR_W-1:0] RX_EN_SET_OFS = 8'h18;
	localparam logic [ADR_W-1:0] RX_EN_CLR_OFS = 8'h1c;
	localparam logic [ADR_W-1:0] MISC_RAW_OFS = 8'h20;
	localparam logic [ADR_W-1:0] MISC_MASKED_OFS = 8'h24;
	localparam logic [ADR_W-1:0] MISC_EN_SET_OFS = 8'h28;
	localparam logic [ADR_W-1:0] MISC_EN_CLR_OFS = 8'h2c;
	localparam logic [ADR_W-1:0] MAC_STATUS_OFS = 8'h30;
	localparam logic [ADR_W-1:0] TX_CP_BASE = 8'h40;
	localparam logic [ADR_W-1:0] RX_CP_BASE = 8'h60;
	localparam logic [ADR_W-1:0] CP_REGION_MASK = 8'he0;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int RX_THR_LSB = 8;
	localparam int MISC_STAT_BIT = 0;
	localparam int MISC_FAULT_BIT = 1;
	localparam int ST_TX_CODE_LSB = 0;
	localparam int ST_TX_CHAN_LSB = 4;
	localparam int ST_RX_CODE_LSB = 8;
	localparam int ST_RX_CHAN_LSB = 12;

	// reset values
	localparam logic [NUM_CHAN-1:0] TX_EN_RST = 8'h00;
	localparam logic [2*NUM_CHAN-1:0] RX_EN_RST = 16'h0000;
	localparam logic [1:0] MISC_EN_RST = 2'h0;
	localparam logic [15:0] MAC_STATUS_RST = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic valid;
		logic [CHAN_W-1:0] chan;
		logic [PTR_W-1:0] addr;
	} emi_store_t;

	typedef struct packed {
		logic valid;
		logic we;
		logic [ADR_W-1:0] addr;
		logic [DAT_W-1:0] data;
		logic [3:0] sel;
	} emi_bus_req_t;
endpackage

// *** core/emi_cpl_ptr.sv ***
// completion pointer store with per-channel pending flags
// assumes one device store and one host acknowledge per cycle at most
`timescale 1ns/1ps
module emi_cpl_ptr #(
	parameter int NCH = emi_pkg::NUM_CHAN
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire emi_pkg::emi_store_t dev_store,
	input wire emi_pkg::emi_store_t host_ack,
	input wire logic [emi_pkg::CHAN_W-1:0] rd_chan,
	output logic [emi_pkg::PTR_W-1:0] rd_ptr,
	output logic [NCH-1:0] pend
);
	typedef struct packed {
		logic [NCH-1:0][emi_pkg::PTR_W-1:0] ptr;
		logic [NCH-1:0] pend;
	} emi_cpl_state_t;

	emi_cpl_state_t st;
	emi_cpl_state_t next_st;

	always_comb begin
		next_st = st;
		// host value is only compared, never stored
		if (host_ack.valid && host_ack.addr == st.ptr[host_ack.chan]) begin
			next_st.pend[host_ack.chan] = 1'b0;
		end
		// device store comes last so a same-cycle event beats the acknowledge
		if (dev_store.valid) begin
			next_st.ptr[dev_store.chan] = dev_store.addr;
			next_st.pend[dev_store.chan] = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rd_ptr = st.ptr[rd_chan];
	assign pend = st.pend;
endmodule

// *** core/emi_wb_slave.sv ***
// classic wishbone slave front end: one request pulse per cycle, registered ack
// assumes read data for the presented address is ready in the same cycle
`timescale 1ns/1ps
module emi_wb_slave (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [emi_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [emi_pkg::DAT_W-1:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [emi_pkg::DAT_W-1:0] rd_data,
	output emi_pkg::emi_bus_req_t req,
	output logic [emi_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o
);
	typedef struct packed {
		logic ack;
		logic [emi_pkg::DAT_W-1:0] dat;
	} emi_wb_state_t;

	emi_wb_state_t st;
	emi_wb_state_t next_st;

	always_comb begin
		// the ack cycle blocks a second take of the same held request
		req.valid = wb_cyc_i && wb_stb_i && !st.ack;
		req.we = wb_we_i;
		req.addr = {wb_adr_i[emi_pkg::ADR_W-1:2], 2'b00};
		req.data = wb_dat_i;
		req.sel = wb_sel_i;
		next_st.ack = req.valid;
		next_st.dat = (req.valid && !wb_we_i) ? rd_data : 32'h0000_0000;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign wb_ack_o = st.ack;
	assign wb_dat_o = st.dat;
endmodule

// *** testbench/emi_irq_events_asserts.sv ***
// checker for the mac interrupt event block, bound to its top module
// assumes one clock mclk and the active-low asynchronous resetn
`timescale 1ns/1ps
module emi_irq_events_asserts #(
	parameter int NCH = 8,
	parameter int NCNT = 36,
	parameter int CW = 16
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [emi_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [emi_pkg::DAT_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire emi_pkg::emi_store_t tx_store,
	input wire logic [emi_pkg::NUM_TX_FAULTS-1:0] tx_fault_flags,
	input wire logic [emi_pkg::NUM_RX_FAULTS-1:0] rx_fault_flags,
	input wire logic [NCNT-1:0] stat_counter_msb,
	input wire logic [NCH*CW-1:0] rx_free_buffer_count,
	input wire logic [NCH*CW-1:0] rx_flow_threshold,
	input wire logic [NCH-1:0] tx_done_irq,
	input wire logic [NCH-1:0] rx_done_irq,
	input wire logic [NCH-1:0] rx_low_buffers_irq,
	input wire logic counter_overflow_irq,
	input wire logic descriptor_fault_irq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	logic wr;
	logic [7:0] wa;
	logic [NCH-1:0] low;
	// address of a taken write, else the read-only offset 00 which no property watches
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o;
	assign wa = wr ? wb_adr_i : 8'h00;
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			low[i] = rx_free_buffer_count[i*CW +: CW] <= rx_flow_threshold[i*CW +: CW];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in one cycle");
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	idle_data_zero_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
		else $error("read data outside ack");
	tx_rise_cause_a: assert property ((tx_done_irq & ~$past(tx_done_irq)) != '0 |->
		$past(tx_store.valid, 2) || $past(wa) == 8'h08) else $error("tx irq rose unasked");
	tx_fall_cause_a: assert property ((~tx_done_irq & $past(tx_done_irq)) != '0 |->
		($past(wa, 2) & 8'he0) == 8'h40 || $past(wa) == 8'h0c) else $error("tx irq fell");
	rx_fall_cause_a: assert property ((~rx_done_irq & $past(rx_done_irq)) != '0 |->
		($past(wa, 2) & 8'he0) == 8'h60 || $past(wa) == 8'h1c) else $error("rx irq fell");
	low_level_a: assert property ((rx_low_buffers_irq & ~$past(low, 2)) == '0)
		else $error("threshold irq without low buffers");
	counter_level_a: assert property (counter_overflow_irq |-> $past(|stat_counter_msb, 2))
		else $error("counter irq without counter msb");
	fault_sticky_a: assert property ($fell(descriptor_fault_irq) |-> $past(wa) == 8'h2c)
		else $error("fault irq dropped without disable");
	fault_cause_a: assert property ($rose(descriptor_fault_irq) |-> $past(wa) == 8'h28 ||
		$past(|{tx_fault_flags, rx_fault_flags}, 2)) else $error("fault irq rose unasked");
	tx_done_c: cover property ($rose(tx_done_irq[0]));
	fault_c: cover property ($rose(descriptor_fault_irq));
	low_c: cover property (rx_low_buffers_irq != '0);
endmodule

bind emi_irq_events emi_irq_events_asserts #(.NCH(NCH), .NCNT(NCNT), .CW(CW)) chk (
	.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.tx_store(tx_store), .tx_fault_flags(tx_fault_flags), .rx_fault_flags(rx_fault_flags),
	.stat_counter_msb(stat_counter_msb), .rx_free_buffer_count(rx_free_buffer_count),
	.rx_flow_threshold(rx_flow_threshold), .tx_done_irq(tx_done_irq),
	.rx_done_irq(rx_done_irq), .rx_low_buffers_irq(rx_low_buffers_irq),
	.counter_overflow_irq(counter_overflow_irq), .descriptor_fault_irq(descriptor_fault_irq));

// *** testbench/emi_dma_model.sv ***
// dma-side model: completion stores and descriptor fault pulses toward the block
// assumes mclk from the bench; every pulse lasts one cycle
`timescale 1ns/1ps
module emi_dma_model (
	input wire logic mclk,
	output emi_pkg::emi_store_t tx_store,
	output emi_pkg::emi_store_t rx_store,
	output logic [emi_pkg::NUM_TX_FAULTS-1:0] tx_fault_flags,
	output logic [emi_pkg::CHAN_W-1:0] tx_fault_chan,
	output logic [emi_pkg::NUM_RX_FAULTS-1:0] rx_fault_flags,
	output logic [emi_pkg::CHAN_W-1:0] rx_fault_chan
);
	initial begin
		tx_store = '0;
		rx_store = '0;
		tx_fault_flags = '0;
		tx_fault_chan = '0;
		rx_fault_flags = '0;
		rx_fault_chan = '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// outside a pulse the qualifiers show the inverse of the last value, never a stale copy
	task automatic store(input logic rx, input logic [2:0] ch, input logic [31:0] a);
		emi_pkg::emi_store_t s;
		s = '{1'b1, ch, a};
		@(posedge mclk);
		if (rx) rx_store <= s;
		else tx_store <= s;
		@(posedge mclk);
		s = '{1'b0, ~ch, ~a};
		if (rx) rx_store <= s;
		else tx_store <= s;
	endtask
	task automatic fault(input logic [5:0] tf, input logic [2:0] tc, input logic [1:0] rf,
		input logic [2:0] rc);
		@(posedge mclk);
		tx_fault_flags <= tf;
		tx_fault_chan <= tc;
		rx_fault_flags <= rf;
		rx_fault_chan <= rc;
		@(posedge mclk);
		tx_fault_flags <= '0;
		tx_fault_chan <= ~tc;
		rx_fault_flags <= '0;
		rx_fault_chan <= ~rc;
	endtask
endmodule

// *** testbench/emi_irq_events_tb.sv ***
// self-checking bench for the mac interrupt event block
// assumes the dma model drives stores and faults; the bench drives bus and levels
`timescale 1ns/1ps
module emi_irq_events_tb;
	localparam logic [7:0] OFS [10] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20,
		8'h24, 8'h30, 8'hfc};
	logic mclk = 0;
	logic resetn = 0;
	logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [7:0] wb_adr_i = '0, tx_done_irq, rx_done_irq, rx_low_buffers_irq, exp_a, adr_q[$];
	logic [31:0] wb_dat_i = '0, wb_dat_o, lf = 32'h1159, a, b, m, exp_q[$];
	logic [35:0] stat_counter_msb = '0;
	logic [127:0] rx_free_buffer_count = {8{16'h0010}}, rx_flow_threshold = '0;
	logic counter_overflow_irq, descriptor_fault_irq;
	emi_pkg::emi_store_t tx_store, rx_store;
	logic [5:0] tx_fault_flags;
	logic [2:0] tx_fault_chan, rx_fault_chan;
	logic [1:0] rx_fault_flags;
	logic [7:0] bk, cp, e;
	int n_fail = 0, compares = 0;
	always #2.5 mclk = ~mclk;
	emi_irq_events uut (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_store(tx_store), .rx_store(rx_store),
		.tx_fault_flags(tx_fault_flags), .tx_fault_chan(tx_fault_chan),
		.rx_fault_flags(rx_fault_flags), .rx_fault_chan(rx_fault_chan),
		.stat_counter_msb(stat_counter_msb), .rx_free_buffer_count(rx_free_buffer_count),
		.rx_flow_threshold(rx_flow_threshold), .tx_done_irq(tx_done_irq),
		.rx_done_irq(rx_done_irq), .rx_low_buffers_irq(rx_low_buffers_irq),
		.counter_overflow_irq(counter_overflow_irq), .descriptor_fault_irq(descriptor_fault_irq));
	emi_dma_model dma (.mclk(mclk), .tx_store(tx_store), .rx_store(rx_store),
		.tx_fault_flags(tx_fault_flags), .tx_fault_chan(tx_fault_chan),
		.rx_fault_flags(rx_fault_flags), .rx_fault_chan(rx_fault_chan));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
		compares++;
		if (g !== ex) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		@(posedge mclk);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= ad;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) chk("ack", 1, 0);
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
		exp_q.push_back(ex);
		adr_q.push_back(ad);
		bus(0, ad, 0);
	endtask
	task automatic do_reset();
		resetn <= 0;
		repeat (8) @(posedge mclk);
		resetn <= 1;
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// read data is judged where the ack appears, against the oldest note
	always @(posedge mclk) begin
		if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0) begin
			exp_a = adr_q.pop_front();
			chk($sformatf("read %h", exp_a), exp_q.pop_front(), wb_dat_o);
		end
	end
	initial begin
		#50000;
		n_fail++;
		complete_run();
	end
	initial begin
		do_reset();
		bus(1, 8'hfc, 32'hffffffff);
		bus(1, 8'h00, 32'hffffffff);
		foreach (OFS[i]) rd(OFS[i], 0);
		for (int d = 0; d < 2; d++) begin
			bk = d ? 8'h10 : 8'h00;
			cp = d ? 8'h60 : 8'h40;
			m = d ? 32'hffff : 32'hff;
			lf = nxt(lf);
			a = lf & m;
			bus(1, bk + 8'h08, a);
			bus(1, bk + 8'h08, 0);
			rd(bk + 8'h08, a);
			lf = nxt(lf);
			b = lf & m;
			bus(1, bk + 8'h0c, b);
			bus(1, bk + 8'h0c, 0);
			rd(bk + 8'h08, a & ~b);
			bus(1, bk + 8'h08, m);
			for (int c = 0; c < 8; c++) begin
				a = nxt(lf);
				lf = nxt(a);
				dma.store(1'(d), 3'(c), a);
				dma.store(1'(d), 3'(c), lf);
				repeat (3) @(posedge mclk);
				chk("done irq", 1, d ? rx_done_irq[c] : tx_done_irq[c]);
				rd(8'(cp + 4 * c), lf);
				bus(1, 8'(cp + 4 * c), a);
				rd(bk, 32'h1 << c);
				rd(8'(cp + 4 * c), lf);
				bus(1, 8'(cp + 4 * c), lf);
				repeat (2) @(posedge mclk);
				chk("done irq", 0, d ? rx_done_irq[c] : tx_done_irq[c]);
			end
			bus(1, bk + 8'h0c, 1);
			dma.store(1'(d), 0, lf);
			repeat (3) @(posedge mclk);
			chk("masked irq", 0, d ? rx_done_irq[0] : tx_done_irq[0]);
			rd(bk, 1);
			rd(bk + 8'h04, 0);
			bus(1, bk + 8'h08, 1);
			rd(bk + 8'h04, 1);
			bus(1, 8'(cp), lf);
		end
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < 8; c++) begin
				lf = nxt(lf);
				e[c] = (c % 2) == p;
				rx_flow_threshold[16*c +: 16] <= lf[15:0] & 16'h7fff;
				rx_free_buffer_count[16*c +: 16] <= (lf[15:0] & 16'h7fff) + 16'(!e[c]);
			end
			repeat (3) @(posedge mclk);
			chk("low irq", e, rx_low_buffers_irq);
			rd(8'h10, {16'h0, e, 8'h00});
		end
		bus(1, 8'h1c, 32'hff00);
		rd(8'h14, 0);
		repeat (2) @(posedge mclk);
		chk("low irq off", 0, rx_low_buffers_irq);
		bus(1, 8'h28, 1);
		lf = nxt(lf);
		stat_counter_msb <= 36'h1 << (lf % 36);
		repeat (3) @(posedge mclk);
		chk("counter irq", 1, counter_overflow_irq);
		rd(8'h20, 1);
		stat_counter_msb <= '0;
		repeat (3) @(posedge mclk);
		chk("counter irq", 0, counter_overflow_irq);
		for (int k = 0; k < 6; k++) begin
			do_reset();
			rd(8'h30, 0);
			bus(1, 8'h28, 2);
			lf = nxt(lf);
			dma.fault(6'h1 << k, lf[2:0], 2'h1 << (k % 2), lf[5:3]);
			repeat (3) @(posedge mclk);
			chk("fault irq", 1, descriptor_fault_irq);
			dma.fault(6'h20, 3'h0, 2'h2, 3'h0);
			rd(8'h30, {17'h0, lf[5:3], 4'(k % 2 + 1), 1'b0, lf[2:0], 4'(k + 1)});
			bus(1, 8'h2c, 2);
			repeat (2) @(posedge mclk);
			chk("fault irq", 0, descriptor_fault_irq);
			rd(8'h20, 2);
			rd(8'h24, 0);
		end
		repeat (4) @(posedge mclk);
		complete_run();
	end
endmodule
